// [shared/iecd_cfg.svh]
`ifndef IECD_CFG_SVH
`define IECD_CFG_SVH

// widths
`define IECD_DW 8
`define IECD_PCW 15
`define IECD_FAW 7
`define IECD_RAW 4
`define IECD_LATW 7

// register offsets
`define IECD_REG_ACC 4'h0
`define IECD_REG_STATUS 4'h1
`define IECD_REG_LATCH 4'h2
`define IECD_REG_PC_LO 4'h3
`define IECD_REG_PC_HI 4'h4
`define IECD_REG_WDT 4'h5

// status field positions
`define IECD_ST_Z 2
`define IECD_ST_PD_N 3
`define IECD_ST_TO_N 4

// reset values
`define IECD_PC_RST 15'h0000
`define IECD_ACC_RST 8'h00
`define IECD_LAT_RST 7'h00
`define IECD_ZERO8 8'h00
`define IECD_ONE15 15'h0001
`define IECD_TWO15 15'h0002

// watchdog timing counts
`define IECD_WDT_PRE_MAX 8'hFF
`define IECD_WDT_CNT_MAX 8'hFF

`endif

// [shared/iecd_pkg.sv]
package iecd_pkg;

    // instruction selector
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_ACC_CALL = 3'h1,
        OP_FILE_ZERO = 3'h2,
        OP_ACC_ZERO = 3'h3,
        OP_WDT_CLEAR = 3'h4,
        OP_FILE_INVERT = 3'h5,
        OP_FILE_DEC = 3'h6,
        OP_DEC_SKIP = 3'h7
    } iecd_op_e;

    // execution phase, one-hot
    typedef enum logic [1:0] {
        ST_RUN = 2'h1,
        ST_SECOND = 2'h2
    } iecd_state_e;

    typedef logic [7:0] iecd_byte_t;
    typedef logic [14:0] iecd_pc_t;

endpackage

// [design/iecd_alu.sv]
`timescale 1ns/100ps
`include "iecd_cfg.svh"

module iecd_alu #(
    parameter int WIDTH = `IECD_DW
) (
    input wire iecd_pkg::iecd_op_e op, // selected operation
    input wire logic [WIDTH-1:0] operand, // file register value
    output logic [WIDTH-1:0] result, // computed value
    output logic zero // result is zero
);

    // complement or decrement of the file operand
    always_comb begin
        case (op)
            iecd_pkg::OP_FILE_INVERT: result = ~operand;
            iecd_pkg::OP_FILE_DEC: result = operand - 1'b1;
            iecd_pkg::OP_DEC_SKIP: result = operand - 1'b1;
            default: result = operand;
        endcase
        zero = (result == '0);
    end

endmodule

// [design/iecd_wdt.sv]
`timescale 1ns/100ps
`include "iecd_cfg.svh"

module iecd_wdt (
    input wire logic sys_clk, // core clock
    input wire logic reset, // sync reset, high
    input wire logic clear, // restart period
    output logic [7:0] count, // counter value
    output logic timeout // expiry pulse
);

    typedef struct packed {
        logic [7:0] pre;
        logic [7:0] cnt;
        logic tmo;
    } iecd_wdt_s;

    iecd_wdt_s q;
    iecd_wdt_s d;

    // prescaler then counter, wrap gives timeout
    always_comb begin
        d = q;
        d.tmo = 1'b0;
        if (clear) begin
            d.pre = `IECD_ZERO8;
            d.cnt = `IECD_ZERO8;
        end else if (q.pre == `IECD_WDT_PRE_MAX) begin
            d.pre = `IECD_ZERO8;
            if (q.cnt == `IECD_WDT_CNT_MAX) begin
                d.cnt = `IECD_ZERO8;
                d.tmo = 1'b1;
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end else begin
            d.pre = q.pre + 8'h01;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count = q.cnt;
    assign timeout = q.tmo;

endmodule

// [design/iecd_top.sv]
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "iecd_cfg.svh"

module iecd_top (
    input wire logic sys_clk, // core instruction clock
    input wire logic reset, // sync reset, high
    // instruction issue
    input wire logic instr_valid, // instruction present
    input wire iecd_pkg::iecd_op_e instr_op, // decoded operation
    input wire logic [6:0] instr_faddr, // file address
    input wire logic instr_dest, // 0 acc, 1 file
    input wire logic [7:0] file_rdata, // addressed file value
    input wire logic sleep_entry, // core enters sleep
    output logic instr_ready, // instruction taken
    output logic flush, // fetched word discarded
    // file register write
    output logic file_we, // write strobe
    output logic [6:0] file_waddr, // write address
    output logic [7:0] file_wdata, // write data
    // return stack push
    output logic stack_push, // push strobe
    output logic [14:0] stack_data, // return address
    // core state
    output logic [14:0] pc, // program counter
    output logic [7:0] acc, // accumulator
    output logic zero_flag, // result null flag
    output logic expiry_status_n, // low after timeout
    output logic sleep_status_n, // low after sleep
    // register port
    input wire logic [3:0] reg_addr, // register offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_we, // write strobe
    input wire logic reg_re, // read strobe
    output logic [7:0] reg_rdata // read data, next cycle
);

    typedef struct packed {
        iecd_pkg::iecd_state_e state;
        logic ready;
        logic flush;
        logic [14:0] pc;
        logic [7:0] acc;
        logic [6:0] latch;
        logic z;
        logic to_n;
        logic pd_n;
        logic fwe;
        logic [6:0] fwa;
        logic [7:0] fwd;
        logic push;
        logic [14:0] push_data;
        logic wdt_clr;
        logic [7:0] rdata;
    } iecd_top_s;

    iecd_top_s q;
    iecd_top_s d;

    logic [7:0] alu_res;
    logic alu_zero;
    logic [7:0] wdt_count;
    logic wdt_timeout;
    logic take;
    logic [14:0] pc_inc;
    logic [7:0] st_byte;

    // file operand arithmetic
    iecd_alu #(
        .WIDTH(`IECD_DW)
    ) u_alu (
        .op(instr_op),
        .operand(file_rdata),
        .result(alu_res),
        .zero(alu_zero)
    );

    // watchdog counter and prescaler
    iecd_wdt u_wdt (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(q.wdt_clr),
        .count(wdt_count),
        .timeout(wdt_timeout)
    );

    // accept only in run phase with ready
    assign take = instr_valid && q.ready &&
                  (q.state == iecd_pkg::ST_RUN);
    assign pc_inc = q.pc + `IECD_ONE15;

    // status byte image
    always_comb begin
        st_byte = `IECD_ZERO8;
        st_byte[`IECD_ST_Z] = q.z;
        st_byte[`IECD_ST_PD_N] = q.pd_n;
        st_byte[`IECD_ST_TO_N] = q.to_n;
    end

    // next state: register port, execution, then events
    always_comb begin
        d = q;
        d.fwe = 1'b0;
        d.push = 1'b0;
        d.flush = 1'b0;
        d.wdt_clr = 1'b0;
        d.rdata = `IECD_ZERO8;
        d.ready = 1'b1;
        // register reads answer one cycle later
        if (reg_re) begin
            case (reg_addr)
                `IECD_REG_ACC: d.rdata = q.acc;
                `IECD_REG_STATUS: d.rdata = st_byte;
                `IECD_REG_LATCH: d.rdata = {1'b0, q.latch};
                `IECD_REG_PC_LO: d.rdata = q.pc[7:0];
                `IECD_REG_PC_HI: d.rdata = {1'b0, q.pc[14:8]};
                `IECD_REG_WDT: d.rdata = wdt_count;
                default: d.rdata = `IECD_ZERO8;
            endcase
        end
        // register writes, overridden by instructions
        if (reg_we) begin
            case (reg_addr)
                `IECD_REG_ACC: d.acc = reg_wdata;
                `IECD_REG_STATUS: d.z = reg_wdata[`IECD_ST_Z];
                `IECD_REG_LATCH: d.latch = reg_wdata[6:0];
                `IECD_REG_PC_LO: d.pc[7:0] = reg_wdata;
                `IECD_REG_PC_HI: d.pc[14:8] = reg_wdata[6:0];
                default: d.latch = d.latch;
            endcase
        end
        case (q.state)
            iecd_pkg::ST_RUN: begin
                if (take) begin
                    d.pc = pc_inc;
                    case (instr_op)
                        iecd_pkg::OP_ACC_CALL: begin
                            d.push = 1'b1;
                            d.push_data = pc_inc;
                            d.pc = {q.latch, q.acc};
                            d.state = iecd_pkg::ST_SECOND;
                            d.ready = 1'b0;
                        end
                        iecd_pkg::OP_FILE_ZERO: begin
                            d.fwe = 1'b1;
                            d.fwa = instr_faddr;
                            d.fwd = `IECD_ZERO8;
                            d.z = 1'b1;
                        end
                        iecd_pkg::OP_ACC_ZERO: begin
                            d.acc = `IECD_ZERO8;
                            d.z = 1'b1;
                        end
                        iecd_pkg::OP_WDT_CLEAR: begin
                            d.wdt_clr = 1'b1;
                            d.to_n = 1'b1;
                            d.pd_n = 1'b1;
                        end
                        iecd_pkg::OP_FILE_INVERT,
                        iecd_pkg::OP_FILE_DEC: begin
                            if (instr_dest) begin
                                d.fwe = 1'b1;
                                d.fwa = instr_faddr;
                                d.fwd = alu_res;
                            end else begin
                                d.acc = alu_res;
                            end
                            d.z = alu_zero;
                        end
                        iecd_pkg::OP_DEC_SKIP: begin
                            if (instr_dest) begin
                                d.fwe = 1'b1;
                                d.fwa = instr_faddr;
                                d.fwd = alu_res;
                            end else begin
                                d.acc = alu_res;
                            end
                            if (alu_zero) begin
                                // next word runs as a no-operation
                                d.pc = q.pc + `IECD_TWO15;
                                d.flush = 1'b1;
                                d.state = iecd_pkg::ST_SECOND;
                                d.ready = 1'b0;
                            end else begin
                                d.pc = pc_inc;
                            end
                        end
                        default: begin
                            d.pc = pc_inc;
                        end
                    endcase
                end
            end
            iecd_pkg::ST_SECOND: begin
                // bubble cycle, presented word is ignored
                d.state = iecd_pkg::ST_RUN;
                d.ready = 1'b1;
            end
            default: begin
                d.state = iecd_pkg::ST_RUN;
            end
        endcase
        // hardware events win over a same-cycle watchdog clear
        if (wdt_timeout) begin
            d.to_n = 1'b0;
        end
        if (sleep_entry) begin
            d.pd_n = 1'b0;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q.state <= iecd_pkg::ST_RUN;
            q.ready <= 1'b1;
            q.flush <= 1'b0;
            q.pc <= `IECD_PC_RST;
            q.acc <= `IECD_ACC_RST;
            q.latch <= `IECD_LAT_RST;
            q.z <= 1'b0;
            q.to_n <= 1'b1;
            q.pd_n <= 1'b1;
            q.fwe <= 1'b0;
            q.fwa <= 7'h00;
            q.fwd <= `IECD_ZERO8;
            q.push <= 1'b0;
            q.push_data <= `IECD_PC_RST;
            q.wdt_clr <= 1'b0;
            q.rdata <= `IECD_ZERO8;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign instr_ready = q.ready;
    assign flush = q.flush;
    assign file_we = q.fwe;
    assign file_waddr = q.fwa;
    assign file_wdata = q.fwd;
    assign stack_push = q.push;
    assign stack_data = q.push_data;
    assign pc = q.pc;
    assign acc = q.acc;
    assign zero_flag = q.z;
    assign expiry_status_n = q.to_n;
    assign sleep_status_n = q.pd_n;
    assign reg_rdata = q.rdata;

endmodule

// [verification/iecd_file_model.sv]
`timescale 1ns/100ps
module iecd_file_model (
    input wire logic sys_clk, // clock
    input wire logic [6:0] faddr, // read address
    input wire logic we, // write strobe
    input wire logic [6:0] waddr, // write address
    input wire logic [7:0] wdata, // write data
    output logic [7:0] rdata // addressed value
);
    logic [7:0] mem [128];
    // small values low down so zero skips occur
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = i < 64 ? 8'(i % 3) : 8'(i * 7);
        end
    end
    // store the write-back
    always @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    // combinational read port
    assign rdata = mem[faddr];
endmodule

// [verification/iecd_top_asserts.sv]
`timescale 1ns/100ps
module iecd_top_asserts (
    input wire logic sys_clk, // clock
    input wire logic reset, // reset
    input wire logic instr_valid, // valid
    input iecd_pkg::iecd_op_e instr_op, // op
    input wire logic [6:0] instr_faddr, // addr
    input wire logic instr_dest, // dest
    input wire logic [7:0] file_rdata, // operand
    input wire logic instr_ready, // ready
    input wire logic flush, // discard
    input wire logic file_we, // write
    input wire logic [6:0] file_waddr, // waddr
    input wire logic [7:0] file_wdata, // wdata
    input wire logic stack_push, // push
    input wire logic [14:0] stack_data, // return
    input wire logic [14:0] pc, // pc
    input wire logic [7:0] acc, // acc
    input wire logic zero_flag, // zero
    input wire logic expiry_status_n, // expiry
    input wire logic sleep_status_n // sleep
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // accepted operations
    wire tk = instr_valid && instr_ready;
    wire call = tk && instr_op == iecd_pkg::OP_ACC_CALL;
    wire fz = tk && instr_op == iecd_pkg::OP_FILE_ZERO;
    wire az = tk && instr_op == iecd_pkg::OP_ACC_ZERO;
    wire wc = tk && instr_op == iecd_pkg::OP_WDT_CLEAR;
    wire inv = tk && instr_op == iecd_pkg::OP_FILE_INVERT;
    wire fd = tk && instr_op == iecd_pkg::OP_FILE_DEC;
    wire sk = tk && instr_op == iecd_pkg::OP_DEC_SKIP;
    wire [7:0] dec = file_rdata - 8'h01;
    AST_CALL_PUSH: assert property (call |=> stack_push
        && stack_data == $past(pc) + 15'h0001) else $error("bad push");
    AST_CALL_PC: assert property (call |=> pc[7:0] == $past(acc))
        else $error("bad call target");
    AST_CALL_TWO: assert property (call |=> !instr_ready
        && $stable(zero_flag) ##1 instr_ready) else $error("bad call");
    AST_FZERO: assert property (fz |=> file_we && file_wdata == 8'h00
        && file_waddr == $past(instr_faddr) && zero_flag)
        else $error("bad file zero");
    AST_AZERO: assert property (az |=> acc == 8'h00 && zero_flag)
        else $error("bad acc zero");
    AST_WDT_BITS: assert property (wc |=> expiry_status_n
        && sleep_status_n && $stable(zero_flag)) else $error("bad bits");
    AST_INVERT: assert property (inv |=>
        ($past(instr_dest) ? file_wdata : acc) == ~$past(file_rdata)
        && zero_flag == ($past(file_rdata) == 8'hFF))
        else $error("bad invert");
    AST_DEC: assert property ((fd || sk) |=>
        ($past(instr_dest) ? file_wdata : acc) == $past(dec))
        else $error("bad decrement");
    AST_SKIP_ZERO: assert property (sk && dec == 8'h00 |=> flush
        && !instr_ready && pc == $past(pc) + 15'h0002 ##1 instr_ready
        && !flush) else $error("bad skip");
    AST_SKIP_GO: assert property (sk && dec != 8'h00 |=> !flush
        && instr_ready && pc == $past(pc) + 15'h0001)
        else $error("bad no skip");
endmodule
bind iecd_top iecd_top_asserts chk_u (.sys_clk, .reset, .instr_valid,
    .instr_op, .instr_faddr, .instr_dest, .file_rdata, .instr_ready,
    .flush, .file_we, .file_waddr, .file_wdata, .stack_push, .stack_data,
    .pc, .acc, .zero_flag, .expiry_status_n, .sleep_status_n);

// [verification/test_instr_exec_call_clear_dec.sv]
`timescale 1ns/100ps
module test_instr_exec_call_clear_dec;
    logic sys_clk = 0, reset = 1, instr_valid = 0, instr_dest = 0;
    logic sleep_entry = 0, reg_we = 0, reg_re = 0, exp_z = 0;
    logic [6:0] instr_faddr = 0, file_waddr, exp_lat = 0;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, file_rdata, file_wdata, acc, reg_rdata;
    logic [7:0] exp_acc = 0;
    logic [14:0] stack_data, pc, exp_pc = 0;
    logic instr_ready, flush, file_we, stack_push, zero_flag;
    logic expiry_status_n, sleep_status_n;
    iecd_pkg::iecd_op_e instr_op = iecd_pkg::OP_NOP;
    int num_errors = 0, total_checks = 0, n;
    // design and data file
    iecd_top dut_u (.sys_clk, .reset, .instr_valid, .instr_op,
        .instr_faddr, .instr_dest, .file_rdata, .sleep_entry, .instr_ready,
        .flush, .file_we, .file_waddr, .file_wdata, .stack_push,
        .stack_data, .pc, .acc, .zero_flag, .expiry_status_n,
        .sleep_status_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
        .reg_rdata);
    iecd_file_model mem_u (.sys_clk, .faddr(instr_faddr), .we(file_we),
        .waddr(file_waddr), .wdata(file_wdata), .rdata(file_rdata));
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] calc(iecd_pkg::iecd_op_e op,
                                        logic [7:0] v);
        if (op == iecd_pkg::OP_FILE_INVERT) return ~v;
        if (op >= iecd_pkg::OP_FILE_DEC) return v - 8'h01;
        return 8'h00;
    endfunction
    // register port cycles
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_we <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata === e, "register read");
        @(posedge sys_clk);
    endtask
    // one instruction, optionally offering a word in the bubble
    task automatic issue(input iecd_pkg::iecd_op_e op, input logic [6:0] fa,
                         input logic d, input logic keep);
        logic [7:0] r;
        logic bub, wr;
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_faddr <= fa;
        instr_dest <= d;
        @(negedge sys_clk);
        r = calc(op, mem_u.mem[fa]);
        bub = op == iecd_pkg::OP_ACC_CALL;
        bub = bub || (op == iecd_pkg::OP_DEC_SKIP && r == 8'h00);
        wr = d && op >= iecd_pkg::OP_FILE_INVERT;
        wr = wr || op == iecd_pkg::OP_FILE_ZERO;
        @(posedge sys_clk);
        instr_valid <= bub && keep;
        instr_op <= iecd_pkg::OP_ACC_ZERO;
        #1;
        chk(file_we === wr, "write strobe");
        if (wr) chk(file_wdata === r && file_waddr === fa, "wdata");
        chk(stack_push === (op == iecd_pkg::OP_ACC_CALL), "push");
        if (op == iecd_pkg::OP_ACC_CALL) begin
            chk(stack_data === exp_pc + 15'h0001, "return");
            exp_pc = {exp_lat, exp_acc};
        end else begin
            exp_pc = exp_pc + (bub ? 15'h0002 : 15'h0001);
        end
        if (op == iecd_pkg::OP_ACC_ZERO || (!d && op >= 3'h5)) exp_acc = r;
        if (op inside {[2:3], [5:6]}) exp_z = r == 8'h00;
        chk(pc === exp_pc, "pc");
        chk(acc === exp_acc && zero_flag === exp_z, "acc");
        chk(instr_ready === !bub && flush === (bub && op == 3'h7), "rdy");
        if (bub) begin
            @(posedge sys_clk);
            instr_valid <= 1'b0;
            #1;
            chk(instr_ready && acc === exp_acc && zero_flag === exp_z
                && pc === exp_pc, "bubble");
        end
    endtask
    // main sequence
    initial begin
        void'($urandom(32'hF033));
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        reg_rd(4'h1, 8'h18);
        reg_rd(4'hF, 8'h00);
        exp_lat = 7'($urandom);
        reg_wr(4'h2, {1'b0, exp_lat});
        exp_acc = 8'($urandom);
        reg_wr(4'h0, exp_acc);
        issue(iecd_pkg::OP_ACC_CALL, 7'h00, 1'b0, 1'b1);
        @(posedge sys_clk);
        issue(iecd_pkg::OP_DEC_SKIP, 7'h01, 1'b0, 1'b1);
        repeat (400) begin
            @(posedge sys_clk);
            if ($urandom_range(7) == 0) begin
                exp_acc = 8'($urandom);
                reg_wr(4'h0, exp_acc);
            end
            issue(iecd_pkg::iecd_op_e'(3'($urandom)), 7'($urandom),
                  1'($urandom), 1'($urandom));
        end
        @(posedge sys_clk);
        reg_wr(4'h1, 8'h00);
        exp_z = 1'b0;
        reg_rd(4'h1, 8'h18);
        @(posedge sys_clk);
        sleep_entry <= 1'b1;
        @(posedge sys_clk);
        sleep_entry <= 1'b0;
        #1 chk(sleep_status_n === 1'b0, "sleep bit");
        n = 0;
        while (expiry_status_n !== 1'b0 && n < 70000) begin
            @(posedge sys_clk);
            n++;
        end
        chk(n < 70000, "no timeout");
        if (n < 70000) begin
            repeat (600) @(posedge sys_clk);
            issue(iecd_pkg::OP_WDT_CLEAR, 7'h00, 1'b0, 1'b0);
            chk(expiry_status_n && sleep_status_n, "status set");
            @(posedge sys_clk);
            reg_wr(4'h5, 8'hFF);
            reg_rd(4'h5, 8'h00);
            reg_rd(4'h3, exp_pc[7:0]);
            reg_rd(4'h4, {1'b0, exp_pc[14:8]});
            reg_rd(4'h0, exp_acc);
            reg_rd(4'h2, {1'b0, exp_lat});
        end
        summarize();
    end
endmodule
